// ===== src/esal_cfg.svh
`ifndef ESAL_CFG_SVH
`define ESAL_CFG_SVH
// Byte addresses of the registers on the APB side.
`define ESAL_OFF_STATUS 12'h040
`define ESAL_OFF_CTRL 12'h100
`define ESAL_OFF_SLEEP 12'h104
`define ESAL_OFF_SMASK 12'h108
`define ESAL_OFF_IRQ_STAT 12'h10C
`define ESAL_OFF_IRQ_MASK 12'h110
// Field positions.
`define ESAL_BIT_ZONE1 0
`define ESAL_BIT_ZONE2 1
`define ESAL_BIT_ZONE3 2
`define ESAL_BIT_ZONE4 3
`define ESAL_BIT_REG_HOT 4
`define ESAL_STATUS_USED 8'h1F
`define ESAL_CTRL_ALERT_EN 0
`define ESAL_CTRL_ASF 1
`define ESAL_CTRL_SUMMARY 8
`define ESAL_IRQ_SET 0
`define ESAL_IRQ_CLR 1
// Reset values.
`define ESAL_RST_STATUS 8'h00
`define ESAL_RST_CTRL 2'h0
`define ESAL_RST_SMASK 2'h0
`define ESAL_RST_IRQ 2'h0
`endif

// ===== src/esal_pkg.sv
package esal_pkg;
  typedef enum logic [1:0] {
    ESAL_S0 = 2'h0,
    ESAL_S3 = 2'h1,
    ESAL_S45 = 2'h3
  } esal_sleep_t;
  typedef struct packed {
    logic zone1_temp_fault;
    logic zone2_temp_fault;
    logic zone3_temp_fault;
    logic zone4_temp_fault;
    logic regulator_hot_input;
  } esal_events_t;
endpackage : esal_pkg

// ===== src/esal_top.sv
`timescale 1ns/1ps
`include "esal_cfg.svh"
// How it works
// - An unmasked event sets its status bit.
// - Summary flag is set while any status bit is set.
// - Alert output follows the summary flag when alert is enabled.
// - Processor-hot fixed-threshold bits never touch summary or alert.
// - Status bits stay set after the condition goes away.
// - Clear is refused while the condition persists and is unmasked.
// - Masked events may be cleared even while still present.
// - In ASF mode a status read clears, as does writing one.
// - Otherwise reads leave bits alone; only writing one clears.
// - Software writes the sleep state; listed events are masked then.
// - Optional masking applies only when the sleep mask bit selects it.
// - Bit 0 flags zone 1; optionally maskable in S3 and S4/5.
// - Bit 1 flags zone 2; optionally maskable in S3 and S4/5.
// - Bit 2 flags zone 3; never masked.
// - Bit 3 flags zone 4; never masked.
// - Bit 4 flags regulator hot; always masked in S3 and S4/5.
// - Zones 1,2 are processors; zone 3 die; zone 4 external digital.
module esal_top
  import esal_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire esal_events_t EVENTS_IN,
  output logic ALERT_OUT,
  output logic IRQ_OUT
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  assign acc = PSEL_IN & PENABLE_IN;
  assign wr = acc & PWRITE_IN & PSTRB_IN[0];
  assign rd = acc & ~PWRITE_IN;
  always_comb begin
    case (PADDR_IN)
      `ESAL_OFF_STATUS,
      `ESAL_OFF_CTRL,
      `ESAL_OFF_SLEEP,
      `ESAL_OFF_SMASK,
      `ESAL_OFF_IRQ_STAT,
      `ESAL_OFF_IRQ_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = acc & ~hit;

  // ---------------------------------------------------------------
  // Control, sleep state and sleep masks
  // ---------------------------------------------------------------
  logic [1:0] ctrl;
  esal_sleep_t sleep_state;
  logic [1:0] sleep_opt_mask;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ctrl <= `ESAL_RST_CTRL;
      sleep_state <= ESAL_S0;
      sleep_opt_mask <= `ESAL_RST_SMASK;
    end else if (wr) begin
      if (PADDR_IN == `ESAL_OFF_CTRL) begin
        ctrl <= PWDATA_IN[1:0];
      end
      if (PADDR_IN == `ESAL_OFF_SLEEP) begin
        case (PWDATA_IN[1:0])
          2'h1: sleep_state <= ESAL_S3;
          2'h3: sleep_state <= ESAL_S45;
          default: sleep_state <= ESAL_S0;
        endcase
      end
      if (PADDR_IN == `ESAL_OFF_SMASK) begin
        sleep_opt_mask <= PWDATA_IN[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Event masking
  // ---------------------------------------------------------------
  // Zones 1 and 2 are processor 1 and 2 temperatures, zone 3 the die and
  // zone 4 the external digital sensor; the caller routes them so.
  logic asleep;
  logic [4:0] cond;
  logic [4:0] masked;
  assign asleep = (sleep_state != ESAL_S0);
  assign cond = {EVENTS_IN.regulator_hot_input, EVENTS_IN.zone4_temp_fault,
                 EVENTS_IN.zone3_temp_fault, EVENTS_IN.zone2_temp_fault,
                 EVENTS_IN.zone1_temp_fault};
  assign masked[`ESAL_BIT_ZONE1] = asleep & sleep_opt_mask[0];
  assign masked[`ESAL_BIT_ZONE2] = asleep & sleep_opt_mask[1];
  assign masked[`ESAL_BIT_ZONE3] = 1'b0;
  assign masked[`ESAL_BIT_ZONE4] = 1'b0;
  assign masked[`ESAL_BIT_REG_HOT] = asleep;

  // ---------------------------------------------------------------
  // Sticky status
  // ---------------------------------------------------------------
  logic [4:0] status;
  logic [4:0] set_vec;
  logic [4:0] clr_req;
  logic [4:0] next_status;
  assign set_vec = cond & ~masked;
  always_comb begin
    clr_req = 5'h00;
    if (PADDR_IN == `ESAL_OFF_STATUS) begin
      if (wr) begin
        clr_req = PWDATA_IN[4:0];
      end else if (rd && ctrl[`ESAL_CTRL_ASF]) begin
        clr_req = 5'h1F;
      end
    end
    // A clear only sticks where the condition is gone or masked; the set
    // term wins over the clear in the same cycle.
    next_status = (status & ~clr_req) | set_vec;
  end
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      status <= 5'(`ESAL_RST_STATUS);
    end else begin
      status <= next_status;
    end
  end

  // ---------------------------------------------------------------
  // Summary and alert
  // ---------------------------------------------------------------
  // This status group holds no processor-hot threshold bits.
  logic summary;
  assign summary = |status;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ALERT_OUT <= 1'b0;
    end else begin
      ALERT_OUT <= ctrl[`ESAL_CTRL_ALERT_EN] & |next_status;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic summary_d;
  logic [1:0] irq_ev;
  assign irq_ev = {summary_d & ~summary, summary & ~summary_d};
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      summary_d <= 1'b0;
      irq_stat <= `ESAL_RST_IRQ;
      irq_mask <= `ESAL_RST_IRQ;
    end else begin
      summary_d <= summary;
      if (wr && PADDR_IN == `ESAL_OFF_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~PWDATA_IN[1:0]) | irq_ev;
      end else begin
        irq_stat <= irq_stat | irq_ev;
      end
      if (wr && PADDR_IN == `ESAL_OFF_IRQ_MASK) begin
        irq_mask <= PWDATA_IN[1:0];
      end
    end
  end
  assign IRQ_OUT = |(irq_stat & irq_mask);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (PADDR_IN)
      `ESAL_OFF_STATUS: next_rdata = {27'h0, status};
      `ESAL_OFF_CTRL: next_rdata = {23'h0, summary, 6'h0, ctrl};
      `ESAL_OFF_SLEEP: next_rdata = {30'h0, sleep_state};
      `ESAL_OFF_SMASK: next_rdata = {30'h0, sleep_opt_mask};
      `ESAL_OFF_IRQ_STAT: next_rdata = {30'h0, irq_stat};
      `ESAL_OFF_IRQ_MASK: next_rdata = {30'h0, irq_mask};
      default: next_rdata = 32'h0000_0000;
    endcase
  end
  // Read data is registered in the setup cycle so it is stable in access.
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      PRDATA_OUT <= next_rdata;
    end
  end

endmodule : esal_top

// ===== tb/esal_top_asserts.sv
`timescale 1ns/1ps
module esal_top_asserts
  import esal_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire esal_events_t EVENTS_IN,
  input wire logic ALERT_OUT,
  input wire logic IRQ_OUT
);
  logic en;
  logic acc;
  assign acc = PSEL_IN && PENABLE_IN;
  // Shadow of the alert enable, tracked from completed writes to the control word.
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      en <= 1'b0;
    end else if (acc && PWRITE_IN && PADDR_IN == 12'h100) begin
      en <= PWDATA_IN[0];
    end
  end
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  a_alert_gated: assert property (!en |=> !ALERT_OUT)
    else $error("alert while disabled");
  a_zone3_alert: assert property (en && !acc && EVENTS_IN.zone3_temp_fault |=> ALERT_OUT)
    else $error("zone 3 event lost");
  a_zone4_alert: assert property (en && !acc && EVENTS_IN.zone4_temp_fault |=> ALERT_OUT)
    else $error("zone 4 event lost");
  a_alert_sticky: assert property (en && ALERT_OUT && !PSEL_IN |=> ALERT_OUT)
    else $error("status dropped alone");
  a_clear_refused: assert property (en && !acc && EVENTS_IN.zone4_temp_fault ##1
    (EVENTS_IN.zone4_temp_fault && PADDR_IN != 12'h100) |=> ALERT_OUT) else $error("clear won");
  a_summary_read: assert property (acc && !PWRITE_IN && PADDR_IN == 12'h100 &&
    $past(ALERT_OUT) |-> PRDATA_OUT[8]) else $error("summary flag low");
  a_rsvd_zero: assert property (acc && !PWRITE_IN && PADDR_IN == 12'h040 |->
    PRDATA_OUT[31:5] == 27'h0) else $error("reserved status bits set");
  a_reset_quiet: assert property ($fell(RST_IN) |-> !ALERT_OUT && !IRQ_OUT)
    else $error("outputs active after reset");
endmodule : esal_top_asserts
bind esal_top esal_top_asserts u_chk (.CLK_IN, .RST_IN, .PADDR_IN, .PSEL_IN, .PENABLE_IN,
  .PWRITE_IN, .PWDATA_IN, .PRDATA_OUT, .EVENTS_IN, .ALERT_OUT, .IRQ_OUT);

// ===== tb/esal_host.sv
`timescale 1ns/1ps
module esal_host (
  input wire logic clk_in,
  input wire logic ready_in,
  input wire logic [31:0] rdata_in,
  output logic [11:0] addr_out,
  output logic sel_out,
  output logic en_out,
  output logic wr_out,
  output logic [31:0] wdata_out,
  output logic hang_out
);
  initial {sel_out, en_out, wr_out, hang_out, addr_out, wdata_out} = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge clk_in);
    sel_out <= 1'b1;
    wr_out <= w;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    en_out <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (!ready_in && n < 16);
    hang_out <= hang_out | !ready_in;
    q = rdata_in;
    sel_out <= 1'b0;
    en_out <= 1'b0;
    // Released write data shows the inverse so stale values are never mistaken.
    wdata_out <= ~d;
  endtask : xfer
endmodule : esal_host

// ===== tb/esal_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("BAD %s exp %0h got %0h", n, e, g); \
    end \
  end
module esal_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] a;
  logic sel, pen, pwr, rdy, err, alert, irq, hang;
  logic [31:0] wd, rd, q;
  esal_pkg::esal_events_t ev = '0;
  int err_total = 0;
  int checked = 0;
  always #25 clk = ~clk;
  esal_host host (.clk_in(clk), .ready_in(rdy), .rdata_in(rd), .addr_out(a), .sel_out(sel),
    .en_out(pen), .wr_out(pwr), .wdata_out(wd), .hang_out(hang));
  esal_top DUT (.CLK_IN(clk), .RST_IN(rst), .PADDR_IN(a), .PSEL_IN(sel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PWDATA_IN(wd), .PSTRB_IN(4'hF), .PRDATA_OUT(rd), .PREADY_OUT(rdy),
    .PSLVERR_OUT(err), .EVENTS_IN(ev), .ALERT_OUT(alert), .IRQ_OUT(irq));
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    host.xfer(1'b1, ad, d, q);
  endtask : wr
  task automatic rc(input string n, input logic [11:0] ad, input logic [31:0] e);
    host.xfer(1'b0, ad, 32'h0, q);
    `CHK(n, e, q)
  endtask : rc
  // Event fields pack msb first: zone1 is 5'h10, zone3 5'h04, zone4 5'h02, hot 5'h01.
  task automatic pulse(input logic [4:0] v);
    ev <= v;
    @(posedge clk);
    ev <= '0;
  endtask : pulse
  task automatic end_sim;
    `CHK("hang", 1'b0, hang)
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rc("stat rst", 12'h040, 32'h0);
    rc("unmapped", 12'h044, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("ready", 1'b1, rdy)
    $display("test reset done");
    wr(12'h100, 32'h1);
    pulse(5'h1F);
    rc("stat all", 12'h040, 32'h1F);
    `CHK("alert", 1'b1, alert)
    rc("summary", 12'h100, 32'h101);
    rc("read keeps", 12'h040, 32'h1F);
    wr(12'h040, 32'hE0);
    rc("zero write", 12'h040, 32'h1F);
    wr(12'h040, 32'h1F);
    rc("w1c", 12'h040, 32'h0);
    rc("sum clear", 12'h100, 32'h1);
    ev <= 5'h02;
    wr(12'h040, 32'h1F);
    rc("refused", 12'h040, 32'h08);
    ev <= '0;
    wr(12'h040, 32'h08);
    $display("test status done");
    for (int s = 1; s < 4; s += 2) begin
      wr(12'h104, 32'(s));
      wr(12'h108, 32'h0);
      ev <= 5'h11;
      rc("sleep opt", 12'h040, 32'h1);
      wr(12'h108, 32'h1);
      wr(12'h040, 32'h1);
      rc("masked clr", 12'h040, 32'h0);
      ev <= '0;
    end
    wr(12'h104, 32'h0);
    $display("test sleep done");
    wr(12'h110, 32'h1);
    wr(12'h10C, 32'h3);
    @(negedge clk);
    `CHK("irq idle", 1'b0, irq)
    pulse(5'h04);
    rc("irq stat", 12'h10C, 32'h1);
    `CHK("irq up", 1'b1, irq)
    wr(12'h110, 32'h0);
    @(negedge clk);
    `CHK("irq mask", 1'b0, irq)
    $display("test irq done");
    wr(12'h100, 32'h3);
    rc("asf read", 12'h040, 32'h04);
    rc("asf clr", 12'h040, 32'h0);
    $display("test asf done");
    end_sim();
  end
endmodule : esal_top_tb
